// File: adc_ctl_pkg.sv
package adc_ctl_pkg;

   localparam int CLK_NS = 20;
   // conversion time per channel and acquisition time per pair, in ns
   localparam int CONV_NS = 400;
   localparam int ACQ_NS = 250;
   // half period of the internally generated serial clock, in ns
   localparam int SCLK_HALF_NS = 40;
   // least times round up to whole cycles
   localparam int CONV_CYC = (CONV_NS + CLK_NS - 1) / CLK_NS;
   localparam int ACQ_CYC = (ACQ_NS + CLK_NS - 1) / CLK_NS;
   localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
   localparam int CNT_W = 8;
   localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_CYC - 1);
   localparam logic [CNT_W-1:0] ACQ_LAST = CNT_W'(ACQ_CYC - 1);
   localparam logic [CNT_W-1:0] SCLK_LAST = CNT_W'(SCLK_HALF_CYC - 1);

   localparam int RES_BITS = 16;
   localparam int FRAME_BITS = 32;
   localparam int FIFO_DEPTH = 8;
   localparam logic [5:0] FRAME_DONE = 6'h20;

   // shared data pins in serial operation
   localparam int PIN_SERIAL_OUT = 8;
   localparam int PIN_SCLK = 9;
   localparam int PIN_OVERRUN = 11;
   localparam int PIN_HI_LSB = 12;
   localparam logic [15:0] PIN_OE_ALL = 16'hFFFF;
   localparam logic [15:0] PIN_OE_NONE = 16'h0000;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_CONV_A = 3'b001,
      ST_CONV_B = 3'b011,
      ST_PUSH = 3'b010,
      ST_LATCH = 3'b110,
      ST_ACQ = 3'b111
   } conv_state_e;

   typedef struct packed {
      logic rst_pin;
      logic start_n;
      logic pd;
      logic cs_n;
      logic rd_n;
      logic sclk;
      logic port_sel;
      logic clk_ext;
      logic impulse;
      logic chan_b;
   } pin_sync_s;

   // start_n rests low so a start held low through reset gives no edge
   localparam pin_sync_s PINS_RST = '{rst_pin: 1'b0, start_n: 1'b0, pd: 1'b0, cs_n: 1'b1, rd_n: 1'b1,
                                      sclk: 1'b0, port_sel: 1'b0, clk_ext: 1'b0, impulse: 1'b0, chan_b: 1'b0};

   typedef struct packed {
      logic [RES_BITS-1:0] chan_a;
      logic [RES_BITS-1:0] chan_b;
   } result_pair_s;

   typedef struct packed {
      logic [15:0] out;
      logic [15:0] oe;
   } pin_bus_s;

   typedef struct packed {
      logic busy;
      logic eoc_n;
      logic hold;
      logic low_power;
   } conv_status_s;

   localparam conv_status_s STATUS_RST = '{busy: 1'b0, eoc_n: 1'b1, hold: 1'b0, low_power: 1'b0};

endpackage

// File: result_fifo.sv
`timescale 1ns/1ps
// depth must be a power of two
module result_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic flush,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW:0] wr_ff;
   logic [AW:0] rd_ff;
   logic [AW:0] nxt_wr;
   logic [AW:0] nxt_rd;
   logic do_wr;
   logic do_rd;

   assign in_ready = !((wr_ff[AW] != rd_ff[AW]) && (wr_ff[AW-1:0] == rd_ff[AW-1:0]));
   assign out_valid = (wr_ff != rd_ff);
   assign out_data = mem_ff[rd_ff[AW-1:0]];
   assign do_wr = in_valid && in_ready;
   assign do_rd = out_valid && out_ready;

   always_comb begin
      nxt_wr = wr_ff;
      nxt_rd = rd_ff;
      if (flush) begin
         nxt_wr = '0;
         nxt_rd = '0;
      end else begin
         if (do_wr) nxt_wr = wr_ff + 1'b1;
         if (do_rd) nxt_rd = rd_ff + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ff <= '0;
         rd_ff <= '0;
      end else begin
         wr_ff <= nxt_wr;
         rd_ff <= nxt_rd;
      end
   end

   // storage needs no reset; pointers guard it
   always_ff @(posedge clk) begin
      if (do_wr && !flush) mem_ff[wr_ff[AW-1:0]] <= in_data;
   end
endmodule

// File: dual_sample_adc_control_port.sv
`timescale 1ns/1ps
module dual_sample_adc_control_port #(
   parameter int DEPTH = adc_ctl_pkg::FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic reset_in,
   input wire logic convert_start_n,
   input wire logic power_down_in,
   input wire logic impulse_mode,
   input wire logic port_select,
   input wire logic serial_clock_source,
   input wire logic chan_b_select,
   input wire logic cs_n,
   input wire logic rd_n,
   input wire logic sclk_in,
   input wire adc_ctl_pkg::result_pair_s sample_in,
   output adc_ctl_pkg::pin_bus_s data_pins,
   output adc_ctl_pkg::conv_status_s status,
   output logic read_overrun_flag
);

////////////////////////////////////////////////////////////////////////////////
   adc_ctl_pkg::pin_sync_s raw;
   adc_ctl_pkg::pin_sync_s s1_ff;
   adc_ctl_pkg::pin_sync_s s2_ff;
   adc_ctl_pkg::pin_sync_s s3_ff;
   adc_ctl_pkg::pin_sync_s pins_q_ff;
   adc_ctl_pkg::pin_sync_s pins_d_ff;
   adc_ctl_pkg::pin_sync_s nxt_pins_q;

   assign raw = {reset_in, convert_start_n, power_down_in, cs_n, rd_n, sclk_in,
                 port_select, serial_clock_source, impulse_mode, chan_b_select};

   // a level counts only once the second and third stages agree
   always_comb begin
      nxt_pins_q = (s3_ff & ~(s2_ff ^ s3_ff)) | (pins_q_ff & (s2_ff ^ s3_ff));
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_ff <= adc_ctl_pkg::PINS_RST;
         s2_ff <= adc_ctl_pkg::PINS_RST;
         s3_ff <= adc_ctl_pkg::PINS_RST;
         pins_q_ff <= adc_ctl_pkg::PINS_RST;
         pins_d_ff <= adc_ctl_pkg::PINS_RST;
      end else begin
         s1_ff <= raw;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         pins_q_ff <= nxt_pins_q;
         pins_d_ff <= pins_q_ff;
      end
   end

   logic start_edge;
   logic rd_en;
   logic serial;
   logic ext;
   assign start_edge = pins_d_ff.start_n && !pins_q_ff.start_n;
   assign rd_en = !pins_q_ff.cs_n && !pins_q_ff.rd_n;
   assign serial = pins_q_ff.port_sel;
   assign ext = pins_q_ff.clk_ext;

////////////////////////////////////////////////////////////////////////////////
   adc_ctl_pkg::conv_state_e state_ff;
   adc_ctl_pkg::conv_state_e nxt_state;
   logic [adc_ctl_pkg::CNT_W-1:0] cnt_ff;
   logic [adc_ctl_pkg::CNT_W-1:0] nxt_cnt;
   adc_ctl_pkg::result_pair_s cap_ff;
   adc_ctl_pkg::result_pair_s nxt_cap;
   adc_ctl_pkg::conv_status_s status_ff;
   adc_ctl_pkg::conv_status_s nxt_status;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic fifo_out_ready;
   logic [adc_ctl_pkg::FRAME_BITS-1:0] fifo_out_data;

   always_comb begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      nxt_cap = cap_ff;
      nxt_status.eoc_n = 1'b1;
      if (pins_q_ff.rst_pin) begin
         nxt_state = adc_ctl_pkg::ST_IDLE;
         nxt_cnt = '0;
      end else begin
         case (state_ff)
            adc_ctl_pkg::ST_IDLE: begin
               if (start_edge && !pins_q_ff.pd) begin
                  nxt_state = adc_ctl_pkg::ST_CONV_A;
                  nxt_cnt = adc_ctl_pkg::CONV_LAST;
                  nxt_cap = sample_in;
               end
            end
            adc_ctl_pkg::ST_CONV_A: begin
               if (cnt_ff == '0) begin
                  nxt_status.eoc_n = 1'b0;
                  nxt_state = adc_ctl_pkg::ST_CONV_B;
                  nxt_cnt = adc_ctl_pkg::CONV_LAST;
               end else begin
                  nxt_cnt = cnt_ff - 1'b1;
               end
            end
            adc_ctl_pkg::ST_CONV_B: begin
               if (cnt_ff == '0) begin
                  nxt_status.eoc_n = 1'b0;
                  nxt_state = adc_ctl_pkg::ST_PUSH;
               end else begin
                  nxt_cnt = cnt_ff - 1'b1;
               end
            end
            // a full buffer stalls here and keeps busy high
            adc_ctl_pkg::ST_PUSH: begin
               if (fifo_in_ready) nxt_state = adc_ctl_pkg::ST_LATCH;
            end
            // busy falls only once the buffer has drained into the shifter
            adc_ctl_pkg::ST_LATCH: begin
               if (!fifo_out_valid) begin
                  nxt_state = adc_ctl_pkg::ST_ACQ;
                  nxt_cnt = adc_ctl_pkg::ACQ_LAST;
               end
            end
            adc_ctl_pkg::ST_ACQ: begin
               if (cnt_ff != '0) begin
                  nxt_cnt = cnt_ff - 1'b1;
               end else if (pins_q_ff.impulse && !pins_q_ff.start_n && !pins_q_ff.pd) begin
                  nxt_state = adc_ctl_pkg::ST_CONV_A;
                  nxt_cnt = adc_ctl_pkg::CONV_LAST;
                  nxt_cap = sample_in;
               end else begin
                  nxt_state = adc_ctl_pkg::ST_IDLE;
               end
            end
            default: nxt_state = adc_ctl_pkg::ST_IDLE;
         endcase
      end
      nxt_status.hold = (nxt_state == adc_ctl_pkg::ST_CONV_A) || (nxt_state == adc_ctl_pkg::ST_CONV_B);
      nxt_status.busy = nxt_status.hold || (nxt_state == adc_ctl_pkg::ST_PUSH) ||
                        (nxt_state == adc_ctl_pkg::ST_LATCH);
      nxt_status.low_power = pins_q_ff.pd && (nxt_state == adc_ctl_pkg::ST_IDLE);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= adc_ctl_pkg::ST_IDLE;
         cnt_ff <= '0;
         cap_ff <= '0;
         status_ff <= adc_ctl_pkg::STATUS_RST;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         cap_ff <= nxt_cap;
         status_ff <= nxt_status;
      end
   end
   assign status = status_ff;

   result_fifo #(
      .WIDTH(adc_ctl_pkg::FRAME_BITS),
      .DEPTH(DEPTH)
   ) u_fifo (
      .clk(clk),
      .rst_n(rst_n),
      .flush(pins_q_ff.rst_pin),
      .in_valid(state_ff == adc_ctl_pkg::ST_PUSH),
      .in_ready(fifo_in_ready),
      .in_data(cap_ff),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready),
      .out_data(fifo_out_data)
   );

////////////////////////////////////////////////////////////////////////////////
   logic [adc_ctl_pkg::FRAME_BITS-1:0] shift_ff;
   logic [adc_ctl_pkg::FRAME_BITS-1:0] nxt_shift;
   logic [5:0] bit_cnt_ff;
   logic [5:0] nxt_bit_cnt;
   logic loaded_ff;
   logic nxt_loaded;
   logic ovr_ff;
   logic nxt_ovr;
   logic serial_result_ff;
   logic nxt_serial_result;
   logic sclk_gen_ff;
   logic nxt_sclk_gen;
   logic [adc_ctl_pkg::CNT_W-1:0] div_ff;
   logic [adc_ctl_pkg::CNT_W-1:0] nxt_div;
   adc_ctl_pkg::pin_bus_s pins_ff;
   adc_ctl_pkg::pin_bus_s nxt_pins;
   logic read_busy;
   logic ext_rise;
   logic int_run;
   logic int_rise;
   logic shift_evt;
   logic load;
   logic [adc_ctl_pkg::RES_BITS-1:0] par_word;

   assign read_busy = (bit_cnt_ff != '0) && (bit_cnt_ff != adc_ctl_pkg::FRAME_DONE);
   // an internally clocked read finishes before the next result is latched
   assign fifo_out_ready = !(serial && !ext && read_busy);
   assign load = fifo_out_valid && fifo_out_ready;
   assign ext_rise = serial && ext && !pins_q_ff.cs_n && pins_q_ff.sclk && !pins_d_ff.sclk;
   assign int_run = serial && !ext && rd_en && loaded_ff &&
                    ((bit_cnt_ff != adc_ctl_pkg::FRAME_DONE) || sclk_gen_ff);
   assign int_rise = int_run && (div_ff == '0) && !sclk_gen_ff && (bit_cnt_ff != adc_ctl_pkg::FRAME_DONE);
   assign shift_evt = (ext_rise || int_rise) && (bit_cnt_ff != adc_ctl_pkg::FRAME_DONE);
   assign par_word = pins_q_ff.chan_b ? shift_ff[adc_ctl_pkg::RES_BITS-1:0] :
                     shift_ff[adc_ctl_pkg::FRAME_BITS-1:adc_ctl_pkg::RES_BITS];

   always_comb begin
      nxt_shift = shift_ff;
      nxt_bit_cnt = bit_cnt_ff;
      nxt_loaded = loaded_ff;
      nxt_ovr = 1'b0;
      nxt_serial_result = serial_result_ff;
      nxt_sclk_gen = 1'b0;
      nxt_div = '0;
      if (pins_q_ff.rst_pin) begin
         nxt_shift = '0;
         nxt_bit_cnt = '0;
         nxt_loaded = 1'b0;
         nxt_serial_result = 1'b0;
      end else if (load) begin
         nxt_shift = fifo_out_data;
         nxt_bit_cnt = '0;
         nxt_loaded = 1'b1;
         nxt_ovr = serial && ext && read_busy;
      end else begin
         if (shift_evt) begin
            nxt_serial_result = shift_ff[adc_ctl_pkg::FRAME_BITS-1];
            nxt_shift = {shift_ff[adc_ctl_pkg::FRAME_BITS-2:0], 1'b0};
            nxt_bit_cnt = bit_cnt_ff + 1'b1;
         end
         if (int_run) begin
            nxt_sclk_gen = sclk_gen_ff;
            nxt_div = div_ff - 1'b1;
            if (div_ff == '0) begin
               nxt_sclk_gen = !sclk_gen_ff;
               nxt_div = adc_ctl_pkg::SCLK_LAST;
            end
         end
      end
      nxt_pins.out = par_word;
      nxt_pins.oe = rd_en ? adc_ctl_pkg::PIN_OE_ALL : adc_ctl_pkg::PIN_OE_NONE;
      if (serial) begin
         nxt_pins.oe = adc_ctl_pkg::PIN_OE_NONE;
         nxt_pins.out[adc_ctl_pkg::PIN_SERIAL_OUT] = serial_result_ff;
         nxt_pins.oe[adc_ctl_pkg::PIN_SERIAL_OUT] = rd_en;
         nxt_pins.out[adc_ctl_pkg::PIN_SCLK] = sclk_gen_ff;
         nxt_pins.oe[adc_ctl_pkg::PIN_SCLK] = !ext;
         nxt_pins.out[adc_ctl_pkg::PIN_OVERRUN] = ovr_ff;
         nxt_pins.oe[adc_ctl_pkg::PIN_OVERRUN] = ext;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         shift_ff <= '0;
         bit_cnt_ff <= '0;
         loaded_ff <= 1'b0;
         ovr_ff <= 1'b0;
         serial_result_ff <= 1'b0;
         sclk_gen_ff <= 1'b0;
         div_ff <= '0;
         pins_ff <= '0;
      end else begin
         shift_ff <= nxt_shift;
         bit_cnt_ff <= nxt_bit_cnt;
         loaded_ff <= nxt_loaded;
         ovr_ff <= nxt_ovr;
         serial_result_ff <= nxt_serial_result;
         sclk_gen_ff <= nxt_sclk_gen;
         div_ff <= nxt_div;
         pins_ff <= nxt_pins;
      end
   end
   assign data_pins = pins_ff;
   assign read_overrun_flag = ovr_ff;

////////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   start_busy_a: assert property ((state_ff == adc_ctl_pkg::ST_IDLE) && start_edge && !pins_q_ff.pd &&
                                  !pins_q_ff.rst_pin |=> status_ff.busy && status_ff.hold)
      else $error("start edge did not raise busy and hold");
   busy_latch_a: assert property ($fell(status_ff.busy) && !$past(pins_q_ff.rst_pin) |-> !fifo_out_valid)
      else $error("busy fell before result latched");
   eoc_pulse_a: assert property ($fell(status_ff.eoc_n) |=> status_ff.eoc_n)
      else $error("channel done pulse longer than one cycle");
   eoc_pair_a: assert property ((state_ff == adc_ctl_pkg::ST_CONV_A) && (cnt_ff == '0) &&
                                !pins_q_ff.rst_pin |=> !status_ff.eoc_n ##1 status_ff.eoc_n ##19 !status_ff.eoc_n)
      else $error("channel done pulses not one per channel");
   pd_block_a: assert property ((state_ff == adc_ctl_pkg::ST_IDLE) && pins_q_ff.pd |=>
                                state_ff == adc_ctl_pkg::ST_IDLE)
      else $error("conversion started while powered down");
   reset_abort_a: assert property (pins_q_ff.rst_pin |=> (state_ff == adc_ctl_pkg::ST_IDLE) && !status_ff.busy)
      else $error("reset pin did not abort conversion");
   impulse_start_a: assert property ((state_ff == adc_ctl_pkg::ST_ACQ) && (cnt_ff == '0) && pins_q_ff.impulse &&
                                     !pins_q_ff.start_n && !pins_q_ff.pd && !pins_q_ff.rst_pin |=>
                                     state_ff == adc_ctl_pkg::ST_CONV_A)
      else $error("impulse mode did not restart conversion");
   hi_zero_a: assert property (serial |=> pins_ff.oe[15:adc_ctl_pkg::PIN_HI_LSB] == 4'h0)
      else $error("upper data pins driven in serial mode");
   out_enable_a: assert property (pins_ff.oe[adc_ctl_pkg::PIN_SERIAL_OUT] |-> $past(rd_en))
      else $error("output enabled without select and read");
   par_bit11_a: assert property (!serial && rd_en |=> pins_ff.out[adc_ctl_pkg::PIN_OVERRUN] ==
                                 $past(par_word[11]) && pins_ff.oe[adc_ctl_pkg::PIN_OVERRUN])
      else $error("parallel bit 11 wrong");
   overrun_a: assert property (ovr_ff |-> $past(serial && ext && read_busy && load))
      else $error("overrun flag without interrupted read");
   sclk_gate_a: assert property (serial && ext && pins_q_ff.cs_n && !load && !pins_q_ff.rst_pin |=>
                                 bit_cnt_ff == $past(bit_cnt_ff))
      else $error("serial clock counted while deselected");
   msb_first_a: assert property (shift_evt && !load && !pins_q_ff.rst_pin |=>
                                 serial_result_ff == $past(shift_ff[31]))
      else $error("serial bit order wrong");
   sclk_dir_a: assert property (serial |=> pins_ff.oe[adc_ctl_pkg::PIN_SCLK] == !$past(ext))
      else $error("serial clock pin direction wrong");
endmodule

// File: serial_host.sv
`timescale 1ns/1ps
module serial_host (
   input wire logic clk,
   input wire logic sdata,
   output logic cs_n,
   output logic rd_n,
   output logic sclk
);
   // clock starts low and rests low outside frames except in idle_clocks
   initial begin
      cs_n = 1'b1;
      rd_n = 1'b1;
      sclk = 1'b0;
   end
   task automatic select(input logic on);
      @(negedge clk);
      cs_n = !on;
      rd_n = !on;
   endtask
   // wrong on purpose: clock edges while not selected
   task automatic idle_clocks(input int n);
      for (int i = 0; i < n; i++) begin
         repeat (4) @(negedge clk);
         sclk = 1'b1;
         repeat (4) @(negedge clk);
         sclk = 1'b0;
      end
   endtask
   // 160 ns clock; the pin lags our edge through the synchroniser, so take it late in the low phase
   task automatic read(input int nbits, input logic keep_cs, output logic [31:0] word);
      word = '0;
      @(negedge clk);
      cs_n = 1'b0;
      rd_n = 1'b0;
      repeat (4) @(negedge clk);
      for (int i = 0; i < nbits; i++) begin
         sclk = 1'b1;
         repeat (4) @(negedge clk);
         sclk = 1'b0;
         repeat (4) @(negedge clk);
         word = {word[30:0], sdata};
      end
      if (!keep_cs) begin
         cs_n = 1'b1;
         rd_n = 1'b1;
      end
   endtask
endmodule

// File: testbench.sv
`timescale 1ns/1ps
module testbench;
   logic clk;
   logic rst_n;
   logic reset_in;
   logic convert_start_n;
   logic power_down_in;
   logic impulse_mode;
   logic port_select;
   logic serial_clock_source;
   logic chan_b_select;
   logic cs_n;
   logic rd_n;
   logic sclk_in;
   adc_ctl_pkg::result_pair_s sample_in;
   adc_ctl_pkg::pin_bus_s data_pins;
   adc_ctl_pkg::conv_status_s status;
   logic read_overrun_flag;
   int error_cnt = 0;
   int comparisons = 0;
   int seed = 32'h2aff;
   int eoc_cnt = 0;
   int ovr_cnt = 0;
   int int_edges = 0;
   logic p9 = 1'b0;
   logic [31:0] word;
   logic [31:0] smp;
   int n;
   ////////////////////////////////////////////////////////////////////////////////
   dual_sample_adc_control_port #(.DEPTH(8)) dut (
      .clk(clk),
      .rst_n(rst_n),
      .reset_in(reset_in),
      .convert_start_n(convert_start_n),
      .power_down_in(power_down_in),
      .impulse_mode(impulse_mode),
      .port_select(port_select),
      .serial_clock_source(serial_clock_source),
      .chan_b_select(chan_b_select),
      .cs_n(cs_n),
      .rd_n(rd_n),
      .sclk_in(sclk_in),
      .sample_in(sample_in),
      .data_pins(data_pins),
      .status(status),
      .read_overrun_flag(read_overrun_flag)
   );
   serial_host host_side (
      .clk(clk),
      .sdata(data_pins.out[8]),
      .cs_n(cs_n),
      .rd_n(rd_n),
      .sclk(sclk_in)
   );
   initial begin
      clk = 1'b0;
      forever #10 clk = !clk;
   end
   always @(posedge clk) begin
      if (status.eoc_n === 1'b0) eoc_cnt++;
      if (read_overrun_flag === 1'b1) ovr_cnt++;
      if (data_pins.out[9] === 1'b1 && p9 === 1'b0 && data_pins.oe[9] === 1'b1) int_edges++;
      p9 <= data_pins.out[9];
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic stop_test();
      $display("comparisons %0d errors %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic wait_busy(input logic lvl);
      int k;
      k = 0;
      while (status.busy !== lvl && k < 300) begin
         @(negedge clk);
         k++;
      end
      check("busy_wait", 32'(k < 300), 32'h1);
   endtask
   // waits out acquisition first, or the start edge would be refused
   task automatic convert(input logic [31:0] val, input logic keep_low, input logic pd_mid);
      repeat (20) @(negedge clk);
      sample_in = val;
      eoc_cnt = 0;
      convert_start_n = 1'b0;
      wait_busy(1'b1);
      check("hold_on", status.hold, 1'b1);
      if (!keep_low) convert_start_n = 1'b1;
      power_down_in = pd_mid;
      wait_busy(1'b0);
      check("eoc_count", eoc_cnt, 32'h2);
      check("hold_off", status.hold, 1'b0);
   endtask
   initial begin
      #(20 * 30000);
      error_cnt++;
      stop_test();
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      rst_n = 1'b0;
      reset_in = 1'b0;
      convert_start_n = 1'b1;
      power_down_in = 1'b0;
      impulse_mode = 1'b0;
      port_select = 1'b0;
      serial_clock_source = 1'b1;
      chan_b_select = 1'b0;
      sample_in = '0;
      repeat (5) @(negedge clk);
      rst_n = 1'b1;
      @(negedge clk);
      check("busy_rst", status.busy, 1'b0);
      check("ovr_rst", read_overrun_flag, 1'b0);
      check("oe_rst", data_pins.oe, adc_ctl_pkg::PIN_OE_NONE);
      for (int i = 0; i < 3; i++) begin
         smp = $random(seed);
         convert(smp, 1'b0, 1'b0);
         // random channel choice first, then the other one
         chan_b_select = smp[0];
         host_side.select(1'b1);
         repeat (8) @(negedge clk);
         check("par_oe", data_pins.oe, adc_ctl_pkg::PIN_OE_ALL);
         check("par_a", data_pins.out, smp[0] ? smp[15:0] : smp[31:16]);
         check("par_bit11", data_pins.out[11], smp[0] ? smp[11] : smp[27]);
         check("par_hi", data_pins.out[15:12], smp[0] ? smp[15:12] : smp[31:28]);
         chan_b_select = !smp[0];
         repeat (8) @(negedge clk);
         check("par_b", data_pins.out, smp[0] ? smp[31:16] : smp[15:0]);
         host_side.select(1'b0);
         repeat (8) @(negedge clk);
         check("par_off", data_pins.oe, adc_ctl_pkg::PIN_OE_NONE);
      end
      port_select = 1'b1;
      for (int i = 0; i < 3; i++) begin
         smp = $random(seed);
         if (i == 0) smp = 32'h8000_0001;
         convert(smp, 1'b0, 1'b0);
         check("ser_oe", data_pins.oe, 16'h0800);
         host_side.idle_clocks(3);
         host_side.read(32, 1'b0, word);
         check("ser_word", word, smp);
      end
      // a read left 5 of 32 bits in when the next result lands
      smp = $random(seed);
      convert(smp, 1'b0, 1'b0);
      host_side.read(5, 1'b1, word);
      ovr_cnt = 0;
      smp = $random(seed);
      convert(smp, 1'b0, 1'b0);
      check("ovr_pulse", ovr_cnt, 32'h1);
      host_side.read(32, 1'b0, word);
      check("ovr_restart", word, smp);
      serial_clock_source = 1'b0;
      smp = $random(seed);
      convert(smp, 1'b0, 1'b0);
      int_edges = 0;
      host_side.select(1'b1);
      repeat (10) @(negedge clk);
      check("int_oe", data_pins.oe[11:8], 4'h3);
      repeat (200) @(negedge clk);
      check("int_edges", int_edges, 32'd32);
      host_side.select(1'b0);
      port_select = 1'b0;
      smp = $random(seed);
      convert(smp, 1'b0, 1'b1);
      repeat (20) @(negedge clk);
      check("low_power", status.low_power, 1'b1);
      convert_start_n = 1'b0;
      n = 0;
      repeat (40) begin
         @(negedge clk);
         if (status.busy !== 1'b0) n++;
      end
      check("pd_refuse", n, 32'h0);
      convert_start_n = 1'b1;
      power_down_in = 1'b0;
      repeat (20) @(negedge clk);
      eoc_cnt = 0;
      convert_start_n = 1'b0;
      repeat (10) @(negedge clk);
      check("busy_pre", status.busy, 1'b1);
      reset_in = 1'b1;
      repeat (6) @(negedge clk);
      check("rst_abort", {status.busy, status.hold}, 2'b00);
      check("rst_eoc", eoc_cnt, 32'h0);
      convert_start_n = 1'b1;
      reset_in = 1'b0;
      impulse_mode = 1'b1;
      smp = $random(seed);
      convert(smp, 1'b1, 1'b0);
      wait_busy(1'b1);
      convert_start_n = 1'b1;
      wait_busy(1'b0);
      impulse_mode = 1'b0;
      repeat (20) @(negedge clk);
      stop_test();
   end
endmodule
